/* File: common/diag_cfg.svh */
// constants for the fieldbus slave diagnostic framer
`ifndef DIAG_CFG_SVH
`define DIAG_CFG_SVH
// ring geometry
`define RING_DEPTH 7'h64
`define RING_LAST 7'h63
`define META_ADDR 7'h64
// frame layout
`define FRAME_LAST 5'h1D
`define DEV_FIRST 5'h07
`define HDR_LEN 6'h18
`define MASTER_NONE 8'hFF
// message codes
`define CODE_PWR_FAIL 8'h1E
`define CODE_READY 8'h3D
`define CODE_XCHG 8'h3E
// address switch value that requests a manual save
`define SW_SAVE 8'h00
// apb register byte addresses
`define REG_IDENT 12'h000
`define REG_STATUS 12'h004
`define REG_TIME 12'h008
`define REG_CTRL 12'h00C
// field positions
`define CTRL_SAVE_BIT 0
`define STAT_CNT_LSB 8
`define STAT_BUSY_BIT 16
`define STAT_TX_BIT 17
`define STAT_HAS_BIT 18
`define META_CNT_LSB 8
// reset values (ident value is arbitrary)
`define IDENT_RST 16'h0000
`endif

/* File: common/diag_pkg.sv */
// types shared by the diagnostic framer
package diag_pkg;
  // 23-byte device-related message, byte 0 in the top bits
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] slot;
    logic [167:0] info;
  } diag_msg_t;
  // one ring entry: time stamp plus message
  typedef struct packed {
    logic [31:0] stamp;
    diag_msg_t msg;
  } ring_entry_t;
  // live standard diagnostic flags
  typedef struct packed {
    logic not_ready;
    logic cfg_fault;
    logic ext_diag;
    logic not_supp;
    logic bad_cfg;
    logic reconfig;
    logic stat_diag;
    logic wdog;
    logic freeze;
    logic sync;
    logic overflow;
  } std_flags_t;
  typedef enum logic [1:0] {
    S_EE_RD = 2'b00,
    S_LOAD = 2'b01,
    S_IDLE = 2'b10,
    S_SAVE = 2'b11
  } fsm_t;
endpackage : diag_pkg

/* File: src/diag_framer.sv */
// diagnostic ring, non-volatile save/restore and telegram framer
//
// Register access over APB and the address map were decided locally.
`include "diag_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module diag_framer
  import diag_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // message logging
  input wire logic log_valid_i,
  input wire diag_msg_t log_msg_i,
  output logic log_ready_o,
  // slave status and switches
  input wire logic data_xchg_i,
  input wire logic [7:0] addr_sw_i,
  input wire std_flags_t std_flags_i,
  input wire logic [7:0] master_addr_i,
  input wire logic configured_i,
  input wire logic pwr_fail_i,
  input wire logic energy_ok_i,
  // telegram byte stream to the bus side
  input wire logic diag_req_i,
  input wire logic tx_ready_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_last_o,
  // flash port, one ring word per acknowledge
  output logic nv_wr_o,
  output logic nv_rd_o,
  output logic [6:0] nv_addr_o,
  output ring_entry_t nv_wdata_o,
  input wire ring_entry_t nv_rdata_i,
  input wire logic nv_ack_i,
  // eeprom port for the power-fail stamp
  output logic ee_wr_o,
  output logic ee_rd_o,
  output logic [31:0] ee_wdata_o,
  input wire logic [31:0] ee_rdata_i,
  input wire logic ee_stamp_valid_i,
  input wire logic ee_ack_i
);

  // whole register state of the block
  typedef struct packed {
    fsm_t fsm;
    logic [6:0] idx;      // flash word index
    logic nv_wr;
    logic nv_rd;
    ring_entry_t nv_wdata;
    logic [6:0] head;     // next ring slot to write
    logic [6:0] count;    // valid ring entries
    logic [31:0] stamp;   // free-running time base
    logic ee_wr;
    logic ee_rd;
    logic [31:0] ee_wdata;
    logic [31:0] ee_stamp;
    logic ee_have;        // stamp found at restart
    logic xchg;           // last seen slave state
    logic sw_zero;        // switch was at 00 last cycle
    logic pf;             // last power-fail level
    logic save_pend;
    logic st_pend;
    logic [7:0] st_code;
    logic pf_log_pend;
    logic pf_tx_pend;
    logic req_pend;
    diag_msg_t last_tx;   // newest transmittable message
    logic has_tx;
    logic tx_busy;
    logic [4:0] tx_idx;
    diag_msg_t tx_msg;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_last;
    logic log_ready;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] ident;
  } state_t;

  state_t s_q; // registered state
  state_t s_d; // next state
  ring_entry_t ring_mem [0:`RING_LAST]; // diagnostic ram, no reset needed
  logic mem_we; // ring write strobe
  logic [6:0] mem_waddr; // ring write slot
  ring_entry_t mem_wdata; // ring write word
  ring_entry_t mem_rdata; // word under the flash save index

  // telegram byte for a frame position
  function automatic logic [7:0] frame_byte(
    input logic [4:0] idx,
    input diag_msg_t msg,
    input std_flags_t f,
    input logic [7:0] maddr,
    input logic cfgd,
    input logic [15:0] ident
  );
    logic [183:0] sh;
    logic [7:0] kb;
    logic [7:0] b;
    kb = {3'h0, idx - `DEV_FIRST};
    sh = msg << {kb, 3'h0};
    unique case (idx)
      5'h00: b = {1'b0, f.bad_cfg, 1'b0, f.not_supp, f.ext_diag,
                  f.cfg_fault, f.not_ready, 1'b0};
      5'h01: b = {2'h0, f.sync, f.freeze, f.wdog, 1'b1,
                  f.stat_diag, f.reconfig};
      5'h02: b = {f.overflow, 7'h00};
      5'h03: b = cfgd ? maddr : `MASTER_NONE;
      5'h04: b = ident[15:8];
      5'h05: b = ident[7:0];
      5'h06: b = {2'h0, `HDR_LEN};
      default: b = sh[183:176];
    endcase
    return b;
  endfunction : frame_byte

  // the save loop reads the slot under its index; meta word is never read
  assign mem_rdata = (s_q.idx < `RING_DEPTH) ? ring_mem[s_q.idx] : '0;

  // next-state logic
  always_comb begin
    ring_entry_t log_e;
    logic do_log;
    logic acc;
    log_e = '0;
    do_log = 1'b0;
    acc = 1'b0;
    s_d = s_q;
    mem_we = 1'b0;
    mem_waddr = s_q.head;
    mem_wdata = '0;
    s_d.stamp = s_q.stamp + 32'h0000_0001;
    // power drop: stamp to eeprom at once, in any state
    s_d.pf = pwr_fail_i;
    if (pwr_fail_i && !s_q.pf) begin
      s_d.ee_wr = 1'b1;
      s_d.ee_wdata = s_q.stamp;
      if (energy_ok_i) begin
        s_d.pf_tx_pend = 1'b1;
      end
    end else if (s_q.ee_wr && ee_ack_i) begin
      s_d.ee_wr = 1'b0;
    end
    // telegram request is remembered until the framer is free
    if (diag_req_i) begin
      s_d.req_pend = 1'b1;
    end
    unique case (s_q.fsm)
      S_EE_RD: begin
        // restart: fetch the stamp left behind by a power drop
        if (s_q.ee_rd && ee_ack_i) begin
          s_d.ee_rd = 1'b0;
          s_d.ee_stamp = ee_rdata_i;
          s_d.ee_have = ee_stamp_valid_i;
          s_d.fsm = S_LOAD;
          s_d.idx = 7'h00;
          s_d.nv_rd = 1'b1;
        end
      end
      S_LOAD: begin
        // restore history before any new message is logged
        if (!s_q.nv_rd) begin
          s_d.nv_rd = 1'b1;
        end else if (nv_ack_i) begin
          s_d.nv_rd = 1'b0;
          if (s_q.idx == `META_ADDR) begin
            // a corrupt pointer word means an empty history
            if (nv_rdata_i[6:0] < `RING_DEPTH &&
                nv_rdata_i[14:8] <= `RING_DEPTH) begin
              s_d.head = nv_rdata_i[6:0];
              s_d.count = nv_rdata_i[14:8];
            end
            s_d.fsm = S_IDLE;
            s_d.pf_log_pend = s_q.ee_have;
            s_d.xchg = data_xchg_i;
            s_d.sw_zero = (addr_sw_i == `SW_SAVE);
          end else begin
            mem_we = 1'b1;
            mem_waddr = s_q.idx;
            mem_wdata = nv_rdata_i;
            s_d.idx = s_q.idx + 7'h01;
          end
        end
      end
      S_IDLE: begin
        // external message wins: its ready was already promised
        if (s_q.log_ready && log_valid_i) begin
          do_log = 1'b1;
          log_e = {s_q.stamp, log_msg_i};
          if (log_msg_i.code != `CODE_READY &&
              log_msg_i.code != `CODE_XCHG) begin
            s_d.last_tx = log_msg_i;
            s_d.has_tx = 1'b1;
          end
        end else if (s_q.pf_log_pend) begin
          do_log = 1'b1;
          log_e = '0;
          log_e.stamp = s_q.ee_stamp;
          log_e.msg.code = `CODE_PWR_FAIL;
          // the restart entry is also what a request transmits next
          s_d.last_tx = log_e.msg;
          s_d.has_tx = 1'b1;
          s_d.pf_log_pend = 1'b0;
        end else if (s_q.st_pend) begin
          do_log = 1'b1;
          log_e = '0;
          log_e.stamp = s_q.stamp;
          log_e.msg.code = s_q.st_code;
          s_d.st_pend = 1'b0;
          s_d.save_pend = 1'b1;
        end else if (s_q.save_pend) begin
          s_d.save_pend = 1'b0;
          s_d.fsm = S_SAVE;
          s_d.idx = 7'h00;
        end
        // status toggles queue an internal message and a save; they sit
        // after the clears above so a new event is never lost
        s_d.xchg = data_xchg_i;
        if (data_xchg_i != s_q.xchg) begin
          s_d.st_pend = 1'b1;
          s_d.st_code = data_xchg_i ? `CODE_XCHG : `CODE_READY;
        end
        s_d.sw_zero = (addr_sw_i == `SW_SAVE);
        if (s_d.sw_zero && !s_q.sw_zero) begin
          s_d.save_pend = 1'b1;
        end
        if (do_log) begin
          mem_we = 1'b1;
          mem_waddr = s_q.head;
          mem_wdata = log_e;
          s_d.head = (s_q.head == `RING_LAST) ? 7'h00 :
                     s_q.head + 7'h01;
          if (s_q.count != `RING_DEPTH) begin
            s_d.count = s_q.count + 7'h01;
          end
        end
      end
      S_SAVE: begin
        // copy every slot, then the pointer word
        if (!s_q.nv_wr) begin
          s_d.nv_wr = 1'b1;
          s_d.nv_wdata = mem_rdata;
          if (s_q.idx == `META_ADDR) begin
            s_d.nv_wdata = '0;
            s_d.nv_wdata[6:0] = s_q.head;
            s_d.nv_wdata[`META_CNT_LSB +: 7] = s_q.count;
          end
        end else if (nv_ack_i) begin
          s_d.nv_wr = 1'b0;
          s_d.idx = s_q.idx + 7'h01;
          if (s_q.idx == `META_ADDR) begin
            s_d.fsm = S_IDLE;
            s_d.idx = 7'h00;
          end
        end
        // toggles and the switch are still watched while saving
        s_d.xchg = data_xchg_i;
        if (data_xchg_i != s_q.xchg) begin
          s_d.st_pend = 1'b1;
          s_d.st_code = data_xchg_i ? `CODE_XCHG : `CODE_READY;
        end
        s_d.sw_zero = (addr_sw_i == `SW_SAVE);
        if (s_d.sw_zero && !s_q.sw_zero) begin
          s_d.save_pend = 1'b1;
        end
      end
    endcase
    // framer: start a telegram, power-fail one first
    if (!s_q.tx_busy && (s_q.pf_tx_pend || s_q.req_pend)) begin
      s_d.tx_busy = 1'b1;
      s_d.tx_idx = 5'h00;
      if (s_q.pf_tx_pend) begin
        s_d.pf_tx_pend = (pwr_fail_i && !s_q.pf && energy_ok_i);
        s_d.tx_msg = '0;
        s_d.tx_msg.code = `CODE_PWR_FAIL;
      end else begin
        s_d.req_pend = diag_req_i;
        s_d.tx_msg = s_q.last_tx;
      end
    end else if (s_q.tx_busy) begin
      if (s_q.tx_valid && tx_ready_i && s_q.tx_last) begin
        s_d.tx_busy = 1'b0;
        s_d.tx_valid = 1'b0;
        s_d.tx_last = 1'b0;
      end else if (!s_q.tx_valid || tx_ready_i) begin
        s_d.tx_valid = 1'b1;
        s_d.tx_data = frame_byte(s_q.tx_idx, s_q.tx_msg, std_flags_i,
                                 master_addr_i, configured_i, s_q.ident);
        s_d.tx_last = (s_q.tx_idx == `FRAME_LAST);
        s_d.tx_idx = s_q.tx_idx + 5'h01;
      end
    end
    // ready is promised only when nothing internal waits
    s_d.log_ready = (s_d.fsm == S_IDLE) && !s_d.st_pend &&
                    !s_d.pf_log_pend && !s_d.save_pend;
    // apb: answer one cycle into the access phase
    acc = psel_i && penable_i && !s_q.pready;
    s_d.pready = acc;
    s_d.pslverr = 1'b0;
    s_d.prdata = 32'h0000_0000;
    if (acc) begin
      unique case (paddr_i)
        `REG_IDENT: begin
          if (pwrite_i) begin
            s_d.ident = pwdata_i[15:0];
          end
          s_d.prdata = {16'h0000, s_q.ident};
        end
        `REG_STATUS: begin
          s_d.prdata[6:0] = s_q.head;
          s_d.prdata[`STAT_CNT_LSB +: 7] = s_q.count;
          s_d.prdata[`STAT_BUSY_BIT] = (s_q.fsm != S_IDLE);
          s_d.prdata[`STAT_TX_BIT] = s_q.tx_busy;
          s_d.prdata[`STAT_HAS_BIT] = s_q.has_tx;
        end
        `REG_TIME: begin
          s_d.prdata = s_q.stamp;
        end
        `REG_CTRL: begin
          // write one to request a save; set wins over the save start
          if (pwrite_i && pwdata_i[`CTRL_SAVE_BIT]) begin
            s_d.save_pend = 1'b1;
          end
        end
        default: begin
          s_d.pslverr = 1'b1;
        end
      endcase
    end
  end

  // state register; the restart begins with the eeprom read
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '0;
      s_q.fsm <= S_EE_RD;
      s_q.ee_rd <= 1'b1;
      s_q.sw_zero <= 1'b1;
      s_q.pf <= 1'b1;
      s_q.ident <= `IDENT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ring memory write port
  always_ff @(posedge core_clk_i) begin
    if (mem_we) begin
      ring_mem[mem_waddr] <= mem_wdata;
    end
  end

  // outputs straight from the state register
  assign prdata_o = s_q.prdata;
  assign pready_o = s_q.pready;
  assign pslverr_o = s_q.pslverr;
  assign log_ready_o = s_q.log_ready;
  assign tx_valid_o = s_q.tx_valid;
  assign tx_data_o = s_q.tx_data;
  assign tx_last_o = s_q.tx_last;
  assign nv_wr_o = s_q.nv_wr;
  assign nv_rd_o = s_q.nv_rd;
  assign nv_addr_o = s_q.idx;
  assign nv_wdata_o = s_q.nv_wdata;
  assign ee_wr_o = s_q.ee_wr;
  assign ee_rd_o = s_q.ee_rd;
  assign ee_wdata_o = s_q.ee_wdata;

endmodule : diag_framer
`default_nettype wire

/* File: tb/diag_framer_monitor.sv */
// port-level assertion checker for the diagnostic framer
`timescale 1ns/1ps
`default_nettype none
module diag_framer_monitor
  import diag_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // status, switches and storage strobes
  input wire logic log_ready_o,
  input wire logic data_xchg_i,
  input wire logic [7:0] addr_sw_i,
  input wire logic [7:0] master_addr_i,
  input wire logic configured_i,
  input wire logic pwr_fail_i,
  input wire logic ee_wr_o,
  input wire logic nv_wr_o,
  // telegram stream
  input wire logic tx_ready_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_last_o
);
  logic [4:0] idx_q; // position of the byte on offer
  // count taken bytes; the last one wraps back to zero
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idx_q <= 5'h00;
    end else if (tx_valid_o && tx_ready_i) begin
      idx_q <= tx_last_o ? 5'h00 : idx_q + 5'h01;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  a_last_pos: assert property (
    tx_valid_o |-> (tx_last_o == (idx_q == 5'h1D)))
    else $error("last flag off byte 29");
  a_byte0_zero: assert property (
    tx_valid_o && idx_q == 5'h00 |-> !tx_data_o[7] && !tx_data_o[5]
    && !tx_data_o[0]) else $error("byte 0 fixed bits wrong");
  a_byte1_one: assert property (
    tx_valid_o && idx_q == 5'h01 |-> tx_data_o[2] && !tx_data_o[7])
    else $error("byte 1 fixed bits wrong");
  a_byte2_res: assert property (
    tx_valid_o && idx_q == 5'h02 |-> tx_data_o[6:0] == 7'h00)
    else $error("byte 2 reserved bits set");
  a_master_addr: assert property (
    tx_valid_o && idx_q == 5'h03 |->
    tx_data_o == (configured_i ? master_addr_i : 8'hFF))
    else $error("master address byte wrong");
  a_hdr_len: assert property (
    tx_valid_o && idx_q == 5'h06 |-> tx_data_o == 8'h18)
    else $error("header length wrong");
  a_no_internal: assert property (
    tx_valid_o && idx_q == 5'h07 |->
    tx_data_o != 8'h3D && tx_data_o != 8'h3E)
    else $error("internal state code sent");
  a_tx_hold: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("byte dropped while stalled");
  a_pwr_stamp: assert property (
    $rose(pwr_fail_i) |-> ##[0:8] ee_wr_o)
    else $error("no stamp write on power drop");
  a_save_toggle: assert property (
    $changed(data_xchg_i) && log_ready_o |-> ##[1:60] nv_wr_o)
    else $error("no flash save on state change");
  a_sw_save: assert property (
    $changed(addr_sw_i) && addr_sw_i == 8'h00 && log_ready_o
    |-> ##[1:60] nv_wr_o) else $error("no flash save on switch");
endmodule : diag_framer_monitor
bind diag_framer diag_framer_monitor diag_framer_monitor_inst (
  .core_clk_i, .rstn_i, .log_ready_o, .data_xchg_i, .addr_sw_i,
  .master_addr_i, .configured_i, .pwr_fail_i, .ee_wr_o, .nv_wr_o,
  .tx_ready_i, .tx_valid_o, .tx_data_o, .tx_last_o);
`default_nettype wire

/* File: tb/diag_nv_model.sv */
// flash, eeprom and telegram sink around the framer
`timescale 1ns/1ps
`default_nettype none
module diag_nv_model
  import diag_pkg::*;
(
  // clock, reset, capture clear
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic clr_i,
  // flash side
  input wire logic nv_wr_i,
  input wire logic nv_rd_i,
  input wire logic [6:0] nv_addr_i,
  input wire ring_entry_t nv_wdata_i,
  output ring_entry_t nv_rdata_o,
  output logic nv_ack_o,
  // eeprom side
  input wire logic ee_wr_i,
  input wire logic ee_rd_i,
  input wire logic [31:0] ee_wdata_i,
  output logic [31:0] ee_rdata_o,
  output logic ee_stamp_valid_o,
  output logic ee_ack_o,
  // telegram sink
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o
);
  ring_entry_t mem [0:100]; // survives resets like real flash
  logic [31:0] ee_q; // stored power-drop stamp
  logic [7:0] frame [0:29]; // captured telegram
  int got; // bytes captured since clear
  // all-zero pointer word means an empty ring at first boot
  initial begin
    for (int i = 0; i < 101; i++) mem[i] = '0;
    ee_stamp_valid_o = 1'b0;
    ee_q = 32'h0;
    got = 0;
  end
  // acks after a random wait; data lines scramble when idle
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nv_ack_o <= 1'b0;
      ee_ack_o <= 1'b0;
      tx_ready_o <= 1'b0;
    end else begin
      nv_ack_o <= (nv_wr_i || nv_rd_i) && !nv_ack_o && $urandom_range(1);
      ee_ack_o <= (ee_wr_i || ee_rd_i) && !ee_ack_o && $urandom_range(1);
      tx_ready_o <= $urandom_range(3) != 0;
      nv_rdata_o <= nv_rd_i ? mem[nv_addr_i] : ~nv_rdata_o;
      ee_rdata_o <= ee_rd_i ? ee_q : ~ee_rdata_o;
      if (nv_wr_i && nv_ack_o) mem[nv_addr_i] <= nv_wdata_i;
      if (ee_wr_i && ee_ack_o) begin
        ee_q <= ee_wdata_i;
        ee_stamp_valid_o <= 1'b1;
      end
      if (clr_i) got <= 0;
      else if (tx_valid_i && tx_ready_o && got < 30) begin
        frame[got] <= tx_data_i;
        got <= got + 1;
      end
    end
  end
endmodule : diag_nv_model
`default_nettype wire

/* File: tb/test_fieldbus_slave_diag_framer.sv */
// self-checking bench for the diagnostic framer
`timescale 1ns/1ps
`default_nettype none
module test_fieldbus_slave_diag_framer
  import diag_pkg::*;
;
  localparam int LIM = 4000; // bound on every wait
  logic core_clk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o;
  logic pslverr_o, log_valid_i, log_ready_o, data_xchg_i, clr;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, ee_wdata_o, ee_rdata_i, q, t0;
  diag_msg_t log_msg_i, last; // last = newest sendable message
  std_flags_t std_flags_i;
  logic [7:0] addr_sw_i, master_addr_i, tx_data_o;
  logic configured_i, pwr_fail_i, energy_ok_i, diag_req_i, tx_ready_i;
  logic tx_valid_o, tx_last_o, nv_wr_o, nv_rd_o, nv_ack_i, ee_wr_o;
  logic ee_rd_o, ee_stamp_valid_i, ee_ack_i, e;
  logic [6:0] nv_addr_o;
  logic [15:0] ident; // mirror of the ident register
  ring_entry_t nv_wdata_o, nv_rdata_i;
  int mismatches, checked;
  diag_framer diag_framer_inst (.*);
  diag_nv_model diag_nv_model_inst (.core_clk_i, .rstn_i, .clr_i(clr),
    .nv_wr_i(nv_wr_o), .nv_rd_i(nv_rd_o), .nv_addr_i(nv_addr_o),
    .nv_wdata_i(nv_wdata_o), .nv_rdata_o(nv_rdata_i), .nv_ack_o(nv_ack_i),
    .ee_wr_i(ee_wr_o), .ee_rd_i(ee_rd_o), .ee_wdata_i(ee_wdata_o),
    .ee_rdata_o(ee_rdata_i), .ee_stamp_valid_o(ee_stamp_valid_i),
    .ee_ack_o(ee_ack_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
    .tx_ready_o(tx_ready_i));
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  // a wait that used its whole bound ends the run
  task automatic bound(input int n);
    if (n >= LIM) begin
      check(0, 1);
      final_report();
    end
  endtask : bound
  // expected telegram byte from the live inputs and the ident and last mirrors
  function automatic logic [7:0] exp_byte(input int i);
    std_flags_t f;
    f = std_flags_i;
    case (i)
      0: return {1'b0, f.bad_cfg, 1'b0, f.not_supp, f.ext_diag,
        f.cfg_fault, f.not_ready, 1'b0};
      1: return {2'b00, f.sync, f.freeze, f.wdog, 1'b1, f.stat_diag,
        f.reconfig};
      2: return {f.overflow, 7'h00};
      3: return configured_i ? master_addr_i : 8'hFF;
      4: return ident[15:8];
      5: return ident[7:0];
      6: return 8'h18;
      default: return last[183 - 8 * (i - 7) -: 8];
    endcase
  endfunction : exp_byte
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    for (n = 0; n < LIM; n++) begin
      @(posedge core_clk_i);
      if (pready_o === 1'b1) break;
    end
    bound(n);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  // offer one message until the ring takes it
  task automatic put(input diag_msg_t m);
    int n;
    @(posedge core_clk_i);
    log_valid_i <= 1'b1;
    log_msg_i <= m;
    for (n = 0; n < LIM; n++) begin
      @(posedge core_clk_i);
      if (log_ready_o === 1'b1) break;
    end
    bound(n);
    log_valid_i <= 1'b0;
    last = m;
  endtask : put
  // wait for a flash save (if asked) and then for idle
  task automatic settle(input logic save);
    int n;
    for (n = 0; n < LIM && save && nv_wr_o !== 1'b1; n++)
      @(posedge core_clk_i);
    bound(n);
    for (n = 0; n < LIM && log_ready_o !== 1'b1; n++)
      @(posedge core_clk_i);
    bound(n);
  endtask : settle
  // collect a telegram started by request or power drop
  task automatic frame(input logic req, input logic pf);
    int n;
    logic [7:0] b;
    @(posedge core_clk_i);
    clr <= 1'b1;
    diag_req_i <= req;
    pwr_fail_i <= pf;
    @(posedge core_clk_i);
    clr <= 1'b0;
    diag_req_i <= 1'b0;
    // the capture count clears at this edge; look only after it
    @(posedge core_clk_i);
    for (n = 0; n < LIM && diag_nv_model_inst.got < 30; n++)
      @(posedge core_clk_i);
    bound(n);
    for (int i = 0; i < 7; i++) begin
      b = diag_nv_model_inst.frame[i];
      check(b, exp_byte(i));
    end
    for (int i = 7; i < 30; i++) begin
      b = diag_nv_model_inst.frame[i];
      check(b, exp_byte(i));
    end
  endtask : frame
  function automatic diag_msg_t rnd_msg();
    diag_msg_t m;
    m.code = 8'($urandom_range(8'h3C, 8'h0A));
    m.slot = 8'($urandom_range(32));
    m.info = 168'({$urandom(), $urandom(), $urandom(), $urandom(),
      $urandom(), $urandom()});
    return m;
  endfunction : rnd_msg
  // reset, then each test in turn
  initial begin
    void'($urandom(96809));
    {psel_i, penable_i, pwrite_i, log_valid_i, data_xchg_i, clr} = '0;
    {configured_i, pwr_fail_i, diag_req_i, rstn_i} = '0;
    {paddr_i, pwdata_i, log_msg_i, std_flags_i, master_addr_i} = '0;
    addr_sw_i = 8'h05;
    energy_ok_i = 1'b1;
    ident = 16'h0000;
    last = '0;
    repeat (3) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    settle(1'b0);
    apb(1'b0, 12'h000, 32'h0);
    check(q[15:0], ident);
    ident = 16'($urandom());
    apb(1'b1, 12'h000, {16'hFFFF, ident});
    apb(1'b0, 12'h000, 32'h0);
    check(q[15:0], ident);
    apb(1'b0, 12'h010, 32'h0);
    check(e, 1'b1);
    check(q, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    t0 = q;
    apb(1'b0, 12'h008, 32'h0);
    check(q - t0, 32'h4);
    $display("test registers done");
    repeat (4) begin
      @(posedge core_clk_i);
      std_flags_i <= std_flags_t'(11'($urandom()));
      master_addr_i <= 8'($urandom());
      configured_i <= 1'($urandom());
      repeat ($urandom_range(3, 1)) put(rnd_msg());
      frame(1'b1, 1'b0);
    end
    $display("test frames done");
    repeat (2) begin
      @(posedge core_clk_i);
      data_xchg_i <= !data_xchg_i;
      settle(1'b1);
      frame(1'b1, 1'b0);
    end
    $display("test state change done");
    repeat (105) put(rnd_msg());
    apb(1'b0, 12'h004, 32'h0);
    check(q[14:8], 7'h64);
    $display("test ring done");
    @(posedge core_clk_i);
    addr_sw_i <= 8'h00;
    settle(1'b1);
    addr_sw_i <= 8'h05;
    apb(1'b1, 12'h00C, 32'h1);
    settle(1'b1);
    $display("test manual save done");
    // drop with too little energy left: stamp only, no telegram
    @(posedge core_clk_i);
    energy_ok_i <= 1'b0;
    pwr_fail_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    check(tx_valid_o, 1'b0);
    pwr_fail_i <= 1'b0;
    energy_ok_i <= 1'b1;
    last = {8'h1E, 176'h0};
    frame(1'b0, 1'b1);
    pwr_fail_i <= 1'b0;
    rstn_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    ident = 16'h0000;
    settle(1'b0);
    apb(1'b0, 12'h004, 32'h0);
    check(q[14:8], 7'h64);
    frame(1'b1, 1'b0);
    $display("test power drop done");
    final_report();
  end
endmodule : test_fieldbus_slave_diag_framer
`default_nettype wire
